/* include/can_msg_map.vh */
// Purpose: constants for the remote I/O node message handler
// Assumes: 25 MHz system clock, APB register access with 32-bit data
// Notes:   definitions only
`ifndef CAN_MSG_MAP_VH
`define CAN_MSG_MAP_VH

// apb register byte offsets
`define OFF_CTRL        8'h00
`define OFF_STATUS      8'h04
`define OFF_RXCOUNT     8'h08
`define OFF_TXCOUNT     8'h0c

// control register fields and reset value
`define CTRL_REPLY_EN   0
`define CTRL_RESET      32'h0000_0001

// fixed identifier bits, node bits go in 8 and 5..3, direction in 0
`define ID_FIXED        11'h284
`define ID_CAL          11'h555
`define ID_DIR_HOST     1'b0
`define ID_DIR_NODE     1'b1

// frame lengths
`define DLC_NORMAL      4'h3
`define DLC_CAL_MIN     4'h2
`define DLC_CAL_MAX     4'h8

// register addresses used by the message logic
`define REG_DATA_IN     4'h0
`define REG_ANALOG_CFG  4'h5
`define REG_ADC_RESULT  4'h8
`define ADC_START_BIT   15

// error warning threshold
`define EW_LIMIT        8'h20

// message spacing in bit times
`define HOLD_BITS       2'h3

// adc set-up time
`define ADC_SETUP_NS    1000
`define CLK_MHZ         25

`endif

/* rtl/node_id_latch.v */
// Purpose: capture node address straps at reset release
// Assumes: pins are asynchronous to i_mclk
// Notes:   pins are free for normal i/o after capture
`include "can_msg_map.vh"

module node_id_latch (
   input  wire       i_mclk,
   input  wire       i_sys_rst,
   input  wire [3:0] i_node_address_pins,
   output wire [3:0] o_node_addr
);

   reg [3:0] sync1_reg;
   reg [3:0] sync2_reg;
   reg       rst_d_reg;
   reg [3:0] addr_reg;

   ////////////////////////////////////////////////////////////////
   // two-flop synchroniser, first stage read only by the second
   always @(posedge i_mclk) begin
      sync1_reg <= i_node_address_pins;
      sync2_reg <= sync1_reg;
   end

   ////////////////////////////////////////////////////////////////
   // latch on the falling edge of reset, seen as first cycle out of it
   always @(posedge i_mclk) begin
      rst_d_reg <= i_sys_rst;
      if (i_sys_rst) begin
         addr_reg <= 4'h0;
      end else if (rst_d_reg) begin
         addr_reg <= sync2_reg;
      end
   end

   assign o_node_addr = addr_reg;

endmodule

/* rtl/msg_spacing_timer.v */
// Purpose: hold off pending messages after a successful transmission
// Assumes: i_bit_tick pulses once per nominal bit time
// Notes:   hold counts whole bit ticks, so it may last up to one bit shorter
`include "can_msg_map.vh"

module msg_spacing_timer (
   input  wire i_mclk,
   input  wire i_sys_rst,
   input  wire i_tx_done,
   input  wire i_bit_tick,
   output wire o_hold
);

   reg [1:0] left_reg;

   ////////////////////////////////////////////////////////////////
   // reload on every success, count down on bit ticks
   always @(posedge i_mclk) begin
      if (i_sys_rst) begin
         left_reg <= 2'h0;
      end else if (i_tx_done) begin
         left_reg <= `HOLD_BITS;
      end else if (i_bit_tick && left_reg != 2'h0) begin
         left_reg <= left_reg - 2'h1;
      end
   end

   assign o_hold = (left_reg != 2'h0);

endmodule

/* rtl/can_msg_core.v */
// Purpose: message handling of a remote i/o node on a can bus
// Assumes: a protocol engine delivers checked frames and sends queued ones
// Notes:   error and overload frames are produced by the protocol engine
//
// Function
// - each received data frame queues a reply with status, address, register contents
// - only standard 11-bit identifier frames are handled; extended ones are ignored
// - two node identifiers differ in bit 0; a third identifier is for calibration
// - identifier is 0,1,a3,1,0,a2,a1,a0,1,0,direction
// - node address straps are latched when reset is released
// - node sends direction 1; host uses 0 in data, 1 in remote frames
// - sent data frames carry three bytes: status and address, then register contents
// - data frames use length 3; calibration frames accept length 2 to 8
// - remote frames with length 3 get the data input register; others ignored
// - never sends remote frames; error and overload frames come from the engine
// - after each successful send, wait three bit times before the next; counted as three bit ticks, so the gap can be just over two
// - status bits of a received first byte are ignored
// - analog config write with start bit replies, waits set-up, converts, sends result
// - frame addressing the result register starts a conversion, reply after it ends
// - calibration frames get only an acknowledge, never a reply
// - entering the calibrated state sends one sign-on frame with data inputs
// - first byte: sign-on, error warning, bus mode hi, lo, register select
// - error warning set when a counter exceeded 32 since last success; 1 in sign-on
//
// Design decisions made here: the APB slave port and the register offsets.
`include "can_msg_map.vh"

module can_msg_core (
   input  wire        i_mclk,
   input  wire        i_sys_rst,
   // apb slave
   input  wire        i_psel,
   input  wire        i_penable,
   input  wire        i_pwrite,
   input  wire [7:0]  i_paddr,
   input  wire [31:0] i_pwdata,
   output reg  [31:0] o_prdata,
   output wire        o_pready,
   output wire        o_pslverr,
   // node address straps
   input  wire [3:0]  i_node_address_pins,
   // received frame from the protocol engine
   input  wire        i_rx_valid,
   input  wire        i_rx_ide,
   input  wire        i_rx_rtr,
   input  wire [10:0] i_rx_id,
   input  wire [3:0]  i_rx_dlc,
   input  wire [7:0]  i_rx_byte0,
   input  wire [7:0]  i_rx_byte1,
   input  wire [7:0]  i_rx_byte2,
   output wire        o_ack_match,
   // frame to send
   output wire        o_tx_req,
   output wire [10:0] o_tx_id,
   output wire        o_tx_rtr,
   output wire [3:0]  o_tx_dlc,
   output reg  [7:0]  o_tx_byte0,
   output reg  [7:0]  o_tx_byte1,
   output reg  [7:0]  o_tx_byte2,
   input  wire        i_tx_done,
   input  wire        i_bit_tick,
   // node state from neighbouring blocks
   input  wire        i_calibrated,
   input  wire [1:0]  i_bus_mode,
   input  wire [7:0]  i_rx_err_count,
   input  wire [7:0]  i_tx_err_count,
   // i/o register file
   output reg         o_reg_wr,
   output reg  [3:0]  o_reg_wr_addr,
   output reg  [15:0] o_reg_wr_data,
   output wire [3:0]  o_reg_rd_addr,
   input  wire [15:0] i_reg_rd_data,
   // converter
   output reg         o_adc_start,
   input  wire        i_adc_done
);

   localparam integer ADC_SETUP_CYC = (`ADC_SETUP_NS * `CLK_MHZ + 999) / 1000;

   localparam [1:0] ADC_IDLE  = 2'h0;
   localparam [1:0] ADC_SETUP = 2'h1;
   localparam [1:0] ADC_CONV  = 2'h2;

   wire [3:0]  node_addr;
   wire        hold;
   wire        frame_std;
   wire        is_data;
   wire        is_remote;
   wire        is_cal;
   wire [3:0]  rx_sel;
   wire        adc_start_bit;
   wire        apb_acc;
   wire        addr_ok;
   wire        tx_load;

   reg  [31:0] ctrl_reg;
   reg  [15:0] rx_count_reg;
   reg  [15:0] tx_count_reg;
   reg         cal_d_reg;
   reg         sign_on_pend_reg;
   reg         reply_pend_reg;
   reg  [3:0]  reply_sel_reg;
   reg         adc_pend_reg;
   reg         ew_reg;
   reg         tx_busy_reg;
   reg  [1:0]  adc_state_reg;
   reg  [1:0]  adc_state_next;
   reg  [5:0]  setup_cnt_reg;
   reg  [3:0]  load_sel;
   reg         load_sign_on;

   ////////////////////////////////////////////////////////////////
   // identifier of this node for a given direction
   function [10:0] node_id;
      input [3:0] addr;
      input       dir;
      begin
         node_id = `ID_FIXED | {2'h0, addr[3], 2'h0, addr[2:0], 2'h0, dir};
      end
   endfunction

   ////////////////////////////////////////////////////////////////
   // address straps and spacing timer
   node_id_latch u_id (
      .i_mclk              (i_mclk),
      .i_sys_rst           (i_sys_rst),
      .i_node_address_pins (i_node_address_pins),
      .o_node_addr         (node_addr)
   );

   msg_spacing_timer u_space (
      .i_mclk     (i_mclk),
      .i_sys_rst  (i_sys_rst),
      .i_tx_done  (i_tx_done),
      .i_bit_tick (i_bit_tick),
      .o_hold     (hold)
   );

   ////////////////////////////////////////////////////////////////
   // frame classification; the higher priority id is for host data frames
   assign frame_std = i_rx_valid && !i_rx_ide;
   assign is_data   = frame_std && !i_rx_rtr && i_rx_dlc == `DLC_NORMAL &&
                      i_rx_id == node_id(node_addr, `ID_DIR_HOST);
   assign is_remote = frame_std && i_rx_rtr && i_rx_dlc == `DLC_NORMAL &&
                      i_rx_id == node_id(node_addr, `ID_DIR_NODE);
   assign is_cal    = frame_std && !i_rx_rtr && i_rx_id == `ID_CAL &&
                      i_rx_dlc >= `DLC_CAL_MIN && i_rx_dlc <= `DLC_CAL_MAX;

   // acknowledge every frame meant for us, calibration included
   assign o_ack_match = is_data || is_remote || is_cal;

   // of the first byte, only the register select nibble matters in host data
   assign rx_sel        = i_rx_byte0[3:0];
   assign adc_start_bit = i_rx_byte1[`ADC_START_BIT - 8];

   ////////////////////////////////////////////////////////////////
   // apply host writes to the i/o register file
   always @(posedge i_mclk) begin
      if (i_sys_rst) begin
         o_reg_wr      <= 1'b0;
         o_reg_wr_addr <= 4'h0;
         o_reg_wr_data <= 16'h0000;
      end else begin
         o_reg_wr <= is_data;
         if (is_data) begin
            o_reg_wr_addr <= rx_sel;
            o_reg_wr_data <= {i_rx_byte1, i_rx_byte2};
         end
      end
   end

   ////////////////////////////////////////////////////////////////
   // sign-on request on entry to calibrated state
   always @(posedge i_mclk) begin
      if (i_sys_rst) begin
         cal_d_reg        <= 1'b0;
         sign_on_pend_reg <= 1'b0;
      end else begin
         cal_d_reg <= i_calibrated;
         if (i_calibrated && !cal_d_reg) begin
            sign_on_pend_reg <= 1'b1;
         end else if (tx_load && load_sign_on) begin
            sign_on_pend_reg <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////
   // reply queue; a new frame wins over the slot being loaded
   always @(posedge i_mclk) begin
      if (i_sys_rst) begin
         reply_pend_reg <= 1'b0;
         reply_sel_reg  <= 4'h0;
      end else if (ctrl_reg[`CTRL_REPLY_EN] && is_data && rx_sel != `REG_ADC_RESULT) begin
         reply_pend_reg <= 1'b1;
         reply_sel_reg  <= rx_sel;
      end else if (ctrl_reg[`CTRL_REPLY_EN] && is_remote) begin
         reply_pend_reg <= 1'b1;
         reply_sel_reg  <= `REG_DATA_IN;
      end else if (tx_load && !load_sign_on && load_sel != `REG_ADC_RESULT) begin
         reply_pend_reg <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////
   // conversion sequencer, next state
   always @* begin
      adc_state_next = adc_state_reg;
      case (adc_state_reg)
         ADC_IDLE: begin
            if (is_data && rx_sel == `REG_ADC_RESULT) begin
               adc_state_next = ADC_CONV;
            end else if (is_data && rx_sel == `REG_ANALOG_CFG && adc_start_bit) begin
               adc_state_next = ADC_SETUP;
            end
         end
         ADC_SETUP: begin
            if (setup_cnt_reg == 6'h00) begin
               adc_state_next = ADC_CONV;
            end
         end
         ADC_CONV: begin
            if (i_adc_done) begin
               adc_state_next = ADC_IDLE;
            end
         end
         default: begin
            adc_state_next = ADC_IDLE;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////
   // conversion sequencer registers; start pulses on entry to conv
   always @(posedge i_mclk) begin
      if (i_sys_rst) begin
         adc_state_reg <= ADC_IDLE;
         setup_cnt_reg <= 6'h00;
         o_adc_start   <= 1'b0;
      end else begin
         adc_state_reg <= adc_state_next;
         o_adc_start   <= (adc_state_next == ADC_CONV) && (adc_state_reg != ADC_CONV);
         if (adc_state_reg == ADC_IDLE) begin
            setup_cnt_reg <= ADC_SETUP_CYC[5:0] - 6'h01;
         end else if (setup_cnt_reg != 6'h00) begin
            setup_cnt_reg <= setup_cnt_reg - 6'h01;
         end
      end
   end

   ////////////////////////////////////////////////////////////////
   // result message queued when the conversion ends
   always @(posedge i_mclk) begin
      if (i_sys_rst) begin
         adc_pend_reg <= 1'b0;
      end else if (adc_state_reg == ADC_CONV && i_adc_done) begin
         adc_pend_reg <= 1'b1;
      end else if (tx_load && !load_sign_on && load_sel == `REG_ADC_RESULT) begin
         adc_pend_reg <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////
   // error warning, sticky since the last successful send
   always @(posedge i_mclk) begin
      if (i_sys_rst) begin
         ew_reg <= 1'b0;
      end else if (i_rx_err_count > `EW_LIMIT || i_tx_err_count > `EW_LIMIT) begin
         ew_reg <= 1'b1;
      end else if (i_tx_done) begin
         ew_reg <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////
   // pick the next message: sign-on, then reply, then conversion result
   always @* begin
      load_sign_on = 1'b0;
      load_sel     = `REG_DATA_IN;
      if (sign_on_pend_reg) begin
         load_sign_on = 1'b1;
      end else if (reply_pend_reg) begin
         load_sel = reply_sel_reg;
      end else if (adc_pend_reg) begin
         load_sel = `REG_ADC_RESULT;
      end
   end

   // held back until calibrated and past the spacing gap; skips the write cycle so a reply sees new contents
   assign tx_load = !tx_busy_reg && !hold && i_calibrated && !o_reg_wr &&
                    (sign_on_pend_reg || reply_pend_reg || adc_pend_reg);
   assign o_reg_rd_addr = load_sel;

   ////////////////////////////////////////////////////////////////
   // transmit slot; register contents are sampled at load time
   always @(posedge i_mclk) begin
      if (i_sys_rst) begin
         tx_busy_reg <= 1'b0;
         o_tx_byte0  <= 8'h00;
         o_tx_byte1  <= 8'h00;
         o_tx_byte2  <= 8'h00;
      end else if (tx_load) begin
         tx_busy_reg <= 1'b1;
         o_tx_byte0  <= {load_sign_on, ew_reg | load_sign_on, i_bus_mode, load_sel};
         o_tx_byte1  <= i_reg_rd_data[15:8];
         o_tx_byte2  <= i_reg_rd_data[7:0];
      end else if (i_tx_done) begin
         tx_busy_reg <= 1'b0;
      end
   end

   assign o_tx_req = tx_busy_reg;
   assign o_tx_id  = node_id(node_addr, `ID_DIR_NODE);
   assign o_tx_rtr = 1'b0;
   assign o_tx_dlc = `DLC_NORMAL;

   ////////////////////////////////////////////////////////////////
   // frame counters for software
   always @(posedge i_mclk) begin
      if (i_sys_rst) begin
         rx_count_reg <= 16'h0000;
         tx_count_reg <= 16'h0000;
      end else begin
         if (o_ack_match) begin
            rx_count_reg <= rx_count_reg + 16'h0001;
         end
         if (i_tx_done) begin
            tx_count_reg <= tx_count_reg + 16'h0001;
         end
      end
   end

   ////////////////////////////////////////////////////////////////
   // apb slave, zero wait states
   assign apb_acc   = i_psel && i_penable;
   assign o_pready  = 1'b1;
   assign addr_ok   = (i_paddr == `OFF_CTRL) || (i_paddr == `OFF_STATUS) ||
                      (i_paddr == `OFF_RXCOUNT) || (i_paddr == `OFF_TXCOUNT);
   assign o_pslverr = apb_acc && !addr_ok;

   // control register write
   always @(posedge i_mclk) begin
      if (i_sys_rst) begin
         ctrl_reg <= `CTRL_RESET;
      end else if (apb_acc && i_pwrite && i_paddr == `OFF_CTRL) begin
         ctrl_reg <= {31'h0000_0000, i_pwdata[`CTRL_REPLY_EN]};
      end
   end

   // read data mux
   always @* begin
      if (i_paddr == `OFF_CTRL) begin
         o_prdata = ctrl_reg;
      end else if (i_paddr == `OFF_STATUS) begin
         o_prdata = {16'h0000, adc_state_reg, i_bus_mode, ew_reg, tx_busy_reg, hold,
                     adc_pend_reg, reply_pend_reg, sign_on_pend_reg, i_calibrated,
                     1'b0, node_addr};
      end else if (i_paddr == `OFF_RXCOUNT) begin
         o_prdata = {16'h0000, rx_count_reg};
      end else if (i_paddr == `OFF_TXCOUNT) begin
         o_prdata = {16'h0000, tx_count_reg};
      end else begin
         o_prdata = 32'h0000_0000;
      end
   end

endmodule

/* bench/can_msg_core_assertions.sv */
// Purpose: concurrent checks on the frame side of the message handler
// Assumes: one clock domain, synchronous active-high reset
// Notes:   node identity is taken from the transmit identifier port
module can_msg_core_assertions (
   input wire        i_mclk,
   input wire        i_sys_rst,
   input wire        i_rx_valid,
   input wire        i_rx_ide,
   input wire        i_rx_rtr,
   input wire [10:0] i_rx_id,
   input wire [3:0]  i_rx_dlc,
   input wire [7:0]  i_rx_byte0,
   input wire [7:0]  i_rx_byte1,
   input wire [7:0]  i_rx_byte2,
   input wire        o_ack_match,
   input wire        o_tx_req,
   input wire [10:0] o_tx_id,
   input wire        o_tx_rtr,
   input wire [3:0]  o_tx_dlc,
   input wire [7:0]  o_tx_byte0,
   input wire [7:0]  o_tx_byte1,
   input wire [7:0]  o_tx_byte2,
   input wire        i_tx_done,
   input wire        i_bit_tick,
   input wire        o_reg_wr,
   input wire [3:0]  o_reg_wr_addr,
   input wire [15:0] o_reg_wr_data
);
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (i_sys_rst);
   ////////////////////////////////////////////////////////////////
   wire       dframe = i_rx_valid && !i_rx_ide && !i_rx_rtr && i_rx_dlc == 4'h3 && i_rx_id == {o_tx_id[10:1], 1'b0};
   wire       rframe = i_rx_valid && !i_rx_ide && i_rx_rtr && i_rx_dlc == 4'h3 && i_rx_id == o_tx_id;
   wire       cframe = i_rx_valid && !i_rx_ide && !i_rx_rtr && i_rx_id == 11'h555 && i_rx_dlc >= 4'h2
                       && i_rx_dlc <= 4'h8;
   reg [7:0]  b0_q, b1_q, b2_q;
   reg        hold_q;
   reg [1:0]  tick_q;
   // last frame bytes, and a tick count that tracks the design's own hold
   always @(posedge i_mclk) begin
      b0_q <= i_rx_byte0;
      b1_q <= i_rx_byte1;
      b2_q <= i_rx_byte2;
      if (i_sys_rst) begin
         hold_q <= 1'b0;
         tick_q <= 2'h0;
      end else if (i_tx_done) begin
         hold_q <= 1'b1;
         tick_q <= 2'h0;
      end else if (hold_q && i_bit_tick) begin
         tick_q <= tick_q + 2'h1;
         hold_q <= (tick_q != 2'h2);
      end
   end
   ////////////////////////////////////////////////////////////////
   reg_write_a: assert property (dframe |=> o_reg_wr && o_reg_wr_addr == b0_q[3:0]
      && o_reg_wr_data == {b1_q, b2_q}) else $error("frame write mismatch");
   data_ack_a: assert property (dframe |-> o_ack_match) else $error("data frame not acknowledged");
   ext_ignore_a: assert property (i_rx_valid && i_rx_ide |-> !o_ack_match ##1 !o_reg_wr)
      else $error("extended frame taken");
   remote_ok_a: assert property (rframe |-> o_ack_match ##1 !o_reg_wr) else $error("remote frame handling");
   remote_len_a: assert property (i_rx_valid && i_rx_rtr && i_rx_dlc != 4'h3 |-> !o_ack_match)
      else $error("bad length remote taken");
   cal_ack_a: assert property (cframe |-> o_ack_match ##1 !o_reg_wr) else $error("calibration frame handling");
   tx_format_a: assert property (o_tx_req |-> o_tx_dlc == 4'h3 && !o_tx_rtr
      && (o_tx_id & 11'h6c7) == 11'h285) else $error("sent frame format");
   tx_stands_a: assert property (o_tx_req && !i_tx_done |=> o_tx_req && $stable(o_tx_byte0)
      && $stable(o_tx_byte1) && $stable(o_tx_byte2)) else $error("request dropped or changed");
   tx_release_a: assert property (o_tx_req && i_tx_done |=> !o_tx_req) else $error("request kept after done");
   spacing_a: assert property (hold_q |-> !o_tx_req) else $error("message inside spacing");
   sign_on_a: assert property (o_tx_req && o_tx_byte0[7] |-> o_tx_byte0[6]
      && o_tx_byte0[3:0] == 4'h0) else $error("sign-on header");
   cover property (dframe);
   cover property (o_tx_req && i_tx_done);
   cover property (o_tx_req && o_tx_byte0[7]);
   cover property (cframe);
endmodule

/* bench/host_can_model.sv */
// Purpose: host controller stand-in that takes queued frames off the node
// Assumes: bit time of eight system clocks
// Notes:   slow mode stalls each frame about forty clocks
module host_can_model (
   input  wire       i_mclk,
   input  wire       i_sys_rst,
   input  wire       i_slow,
   input  wire       i_tx_req,
   input  wire [7:0] i_tx_byte0,
   input  wire [7:0] i_tx_byte1,
   input  wire [7:0] i_tx_byte2,
   output reg        o_tx_done,
   output reg        o_bit_tick
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [23:0] got [$];
   reg   [2:0]  tick_cnt;
   reg   [5:0]  lag;
   // frame completes after a lag; done never shares a cycle with a tick
   always @(posedge i_mclk) begin
      if (i_sys_rst) begin
         tick_cnt <= 3'h0;
         lag <= 6'h00;
         o_tx_done <= 1'b0;
         o_bit_tick <= 1'b0;
      end else begin
         tick_cnt <= tick_cnt + 3'h1;
         o_bit_tick <= (tick_cnt == 3'h7);
         o_tx_done <= 1'b0;
         if (!i_tx_req || o_tx_done) lag <= 6'h00;
         else if (lag < (i_slow ? 6'h28 : 6'h04)) lag <= lag + 6'h01;
         else if (tick_cnt != 3'h7) begin
            o_tx_done <= 1'b1;
            got.push_back({i_tx_byte0, i_tx_byte1, i_tx_byte2});
         end
      end
   end
endmodule

/* bench/can_msg_core_tb.sv */
// Purpose: frame and register tests of the message handler
// Assumes: node straps 4'ha, bus mode 2
// Notes:   register file and converter are simple stand-ins here
module can_msg_core_tb;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [3:0] NODE = 4'ha;
   logic        i_mclk = 1'b0, i_sys_rst = 1'b1, i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
   logic        i_rx_valid = 1'b0, i_rx_ide = 1'b0, i_rx_rtr = 1'b0, i_calibrated = 1'b0;
   logic        i_adc_done = 1'b0, i_slow = 1'b0, ack, err;
   logic        o_pready, o_pslverr, o_ack_match, o_tx_req, o_tx_rtr, i_tx_done, i_bit_tick, o_reg_wr, o_adc_start;
   logic [7:0]  i_paddr = 8'h00, i_rx_byte0 = 8'h00, i_rx_byte1 = 8'h00, i_rx_byte2 = 8'h00;
   logic [7:0]  i_rx_err_count = 8'h00, i_tx_err_count = 8'h00, o_tx_byte0, o_tx_byte1, o_tx_byte2;
   logic [31:0] i_pwdata = 32'h0, o_prdata, rd;
   logic [10:0] i_rx_id = 11'h000, o_tx_id;
   logic [3:0]  i_rx_dlc = 4'h0, i_node_address_pins = NODE, o_tx_dlc, o_reg_wr_addr, o_reg_rd_addr;
   logic [1:0]  i_bus_mode = 2'h2;
   logic [15:0] o_reg_wr_data, i_reg_rd_data, adc_val, regs [16];
   int          n_fail = 0, check_count = 0, n_tx = 0;

   can_msg_core uut (.*);
   host_can_model host (.i_mclk, .i_sys_rst, .i_slow, .i_tx_req(o_tx_req), .i_tx_byte0(o_tx_byte0),
      .i_tx_byte1(o_tx_byte1), .i_tx_byte2(o_tx_byte2), .o_tx_done(i_tx_done), .o_bit_tick(i_bit_tick));
   ////////////////////////////////////////////////////////////////
   always #20 i_mclk = ~i_mclk;
   // register file: data inputs and result are read-only, so writes skip them
   assign i_reg_rd_data = regs[o_reg_rd_addr];
   always @(posedge i_mclk) begin
      if (o_reg_wr && o_reg_wr_addr != 4'h0 && o_reg_wr_addr != 4'h8) regs[o_reg_wr_addr] <= o_reg_wr_data;
   end
   // converter: result lands with the done pulse twenty clocks after start
   always @(posedge i_mclk) begin
      if (o_adc_start) begin
         repeat (20) @(posedge i_mclk);
         regs[8] <= adc_val;
         i_adc_done <= 1'b1;
         @(posedge i_mclk);
         i_adc_done <= 1'b0;
      end
   end
   ////////////////////////////////////////////////////////////////
   function automatic logic [10:0] nid(input logic dir);
      return {2'b01, NODE[3], 2'b10, NODE[2:0], 2'b10, dir};
   endfunction
   function automatic logic [7:0] hdr(input logic [3:0] a);
      return {2'b00, i_bus_mode, a};
   endfunction
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      check_count++;
      if (g !== e) begin
         n_fail++;
         $display("BAD %0t got %h expected %h", $time, g, e);
      end
   endtask
   // a frame must reach the host in bounded time
   task automatic chk_frame(input logic [23:0] e);
      int t = 0;
      while (host.got.size() == 0 && t < 800) begin
         @(posedge i_mclk);
         t++;
      end
      if (host.got.size() == 0) chk(32'h1, 32'h0);
      else begin
         n_tx++;
         chk({8'h00, host.got.pop_front()}, {8'h00, e});
      end
   endtask
   task automatic quiet();
      repeat (200) @(posedge i_mclk);
      chk(host.got.size(), 0);
   endtask
   // one apb transfer, held until pready is sampled high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int t = 0;
      @(posedge i_mclk);
      i_psel <= 1'b1;
      i_pwrite <= w;
      i_paddr <= a;
      i_pwdata <= d;
      @(posedge i_mclk);
      i_penable <= 1'b1;
      do begin
         @(posedge i_mclk);
         t++;
      end while (o_pready !== 1'b1 && t < 50);
      rd = o_prdata;
      err = o_pslverr;
      i_psel <= 1'b0;
      i_penable <= 1'b0;
   endtask
   // host side frame, one cycle; acknowledge is combinational
   task automatic send(input logic rtr, ide, input logic [10:0] id, input logic [3:0] dlc, input logic [23:0] b);
      @(posedge i_mclk);
      i_rx_valid <= 1'b1;
      i_rx_rtr <= rtr;
      i_rx_ide <= ide;
      i_rx_id <= id;
      i_rx_dlc <= dlc;
      {i_rx_byte0, i_rx_byte1, i_rx_byte2} <= b;
      #1 ack = o_ack_match;
      @(posedge i_mclk);
      i_rx_valid <= 1'b0;
   endtask
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////
   initial begin
      foreach (regs[k]) regs[k] = 16'h0000;
      regs[0] = 16'h1234;
      repeat (16) @(posedge i_mclk);
      i_sys_rst <= 1'b0;
      repeat (5) @(posedge i_mclk);
      i_node_address_pins <= 4'h5;
      repeat (3) @(posedge i_mclk);
      chk(o_tx_id, nid(1'b1));
      apb(1'b0, 8'h00, 32'h0);
      chk(rd, 32'h1);
      apb(1'b0, 8'h04, 32'h0);
      chk(rd[3:0], NODE);
      apb(1'b0, 8'h10, 32'h0);
      chk(err, 1'b1);
      i_calibrated <= 1'b1;
      chk_frame({2'b11, i_bus_mode, 4'h0, 16'h1234});
      for (int a = 1; a < 8; a++) begin
         send(1'b0, 1'b0, nid(1'b0), 4'h3, {4'hf, a[3:0], a[7:0] + 8'h10, a[7:0] ^ 8'h5a});
         chk_frame({hdr(a[3:0]), a[7:0] + 8'h10, a[7:0] ^ 8'h5a});
      end
      send(1'b1, 1'b0, nid(1'b1), 4'h3, 24'h0);
      chk_frame({hdr(4'h0), 16'h1234});
      send(1'b1, 1'b0, nid(1'b1), 4'h2, 24'h0);
      chk(ack, 1'b0);
      send(1'b0, 1'b1, nid(1'b0), 4'h3, 24'h010203);
      chk(ack, 1'b0);
      send(1'b0, 1'b0, nid(1'b0) ^ 11'h008, 4'h3, 24'h010203);
      chk(ack, 1'b0);
      send(1'b0, 1'b0, nid(1'b1), 4'h3, 24'h010203);
      chk(ack, 1'b0);
      send(1'b0, 1'b0, nid(1'b0), 4'h2, 24'h010203);
      chk(ack, 1'b0);
      for (int d = 0; d < 16; d++) begin
         send(1'b0, 1'b0, 11'h555, d[3:0], 24'h0);
         chk(ack, d >= 2 && d <= 8);
      end
      quiet();
      adc_val = 16'h3a40;
      send(1'b0, 1'b0, nid(1'b0), 4'h3, 24'h080000);
      chk_frame({hdr(4'h8), 16'h3a40});
      adc_val = 16'h0c81;
      send(1'b0, 1'b0, nid(1'b0), 4'h3, 24'h058031);
      chk_frame({hdr(4'h5), 16'h8031});
      chk_frame({hdr(4'h8), 16'h0c81});
      // slow host; a count of exactly 32 is not above the limit
      i_slow <= 1'b1;
      i_tx_err_count <= 8'h20;
      @(posedge i_mclk);
      i_tx_err_count <= 8'h00;
      send(1'b0, 1'b0, nid(1'b0), 4'h3, 24'h02beef);
      chk_frame({hdr(4'h2), 16'hbeef});
      i_rx_err_count <= 8'h21;
      @(posedge i_mclk);
      i_rx_err_count <= 8'h00;
      send(1'b0, 1'b0, nid(1'b0), 4'h3, 24'h02beef);
      chk_frame({2'b01, i_bus_mode, 4'h2, 16'hbeef});
      send(1'b0, 1'b0, nid(1'b0), 4'h3, 24'h02beef);
      chk_frame({hdr(4'h2), 16'hbeef});
      apb(1'b1, 8'h00, 32'h0);
      send(1'b0, 1'b0, nid(1'b0), 4'h3, 24'h03aaaa);
      quiet();
      apb(1'b1, 8'h00, 32'h1);
      apb(1'b0, 8'h0c, 32'h0);
      chk(rd, n_tx);
      give_verdict();
   end
   initial begin
      #3000000;
      n_fail++;
      give_verdict();
   end
endmodule

bind can_msg_core can_msg_core_assertions watch (.i_mclk, .i_sys_rst, .i_rx_valid, .i_rx_ide, .i_rx_rtr,
   .i_rx_id, .i_rx_dlc, .i_rx_byte0, .i_rx_byte1, .i_rx_byte2, .o_ack_match, .o_tx_req, .o_tx_id, .o_tx_rtr,
   .o_tx_dlc, .o_tx_byte0, .o_tx_byte1, .o_tx_byte2, .i_tx_done, .i_bit_tick, .o_reg_wr, .o_reg_wr_addr,
   .o_reg_wr_data);
